// ---- core/hwmac_datapath.sv ----
// Combinational halfword multiplier, accumulator and saturation stage.
// Assumes operands are stable for the cycle in which the result is registered.
`timescale 1ns/1ps
module hwmac_datapath (
    input  wire logic [31:0]          source_a_gpr,
    input  wire logic [31:0]          source_b_gpr,
    input  wire logic [31:0]          target_gpr,
    input  wire hwmac_pkg::hwmac_op_t op,
    output hwmac_pkg::hwmac_res_t     res
);
    import hwmac_pkg::*;

    logic [15:0]        half_a;
    logic [15:0]        half_b;
    logic signed [31:0] ext_a;
    logic signed [31:0] ext_b;
    logic               sgn;
    logic               neg;
    logic [32:0]        sum;
    logic               sovf;

    always_comb begin
        // Bits 0:15 are the upper half, 16:31 the lower half
        half_a = (op.pair == PAIR_HIGH) ? source_a_gpr[31:16] : source_a_gpr[15:0];
        half_b = (op.pair == PAIR_LOW) ? source_b_gpr[15:0] : source_b_gpr[31:16];
        neg = (op.kind == KIND_NMAC_MOD) || (op.kind == KIND_NMAC_SAT);
        // Negative forms only exist signed, so the unsigned bit is ignored there
        sgn = !op.uns || neg;
        if (sgn) begin
            ext_a = {{16{half_a[15]}}, half_a};
            ext_b = {{16{half_b[15]}}, half_b};
        end else begin
            ext_a = {16'h0000, half_a};
            ext_b = {16'h0000, half_b};
        end
        res.raw    = ext_a * ext_b;
        res.addend = neg ? (32'h0000_0000 - res.raw) : res.raw;
        sum  = {1'b0, res.addend} + {1'b0, target_gpr};
        sovf = (res.addend[31] == target_gpr[31]) && (sum[31] != target_gpr[31]);
        res.ovf = sgn ? sovf : sum[32];
        case (op.kind)
            KIND_MAC_MOD, KIND_NMAC_MOD: res.result = sum[31:0];
            KIND_MAC_SAT, KIND_NMAC_SAT: begin
                if (!sgn) begin
                    res.result = sum[31:0] | {32{sum[32]}};
                end else if (sovf) begin
                    res.result = {target_gpr[31], {31{~target_gpr[31]}}};
                end else begin
                    res.result = sum[31:0];
                end
            end
            default: res.result = res.raw;
        endcase
    end

endmodule : hwmac_datapath

// ---- core/hwmac_pkg.sv ----
// Constants, op encoding and carrier types of the halfword multiply-accumulate unit.
// Assumes a single pclk domain and an APB master with 32-bit data.
package hwmac_pkg;

    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned OP_W     = 8;
    localparam int unsigned COND_W   = 4;
    localparam int unsigned XFLAG_W  = 2;

    localparam logic [ADDR_W-1:0] OFS_SRC_A  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SRC_B  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OP     = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_COND   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_XFLAG  = 8'h14;

    // Condition field zero bit positions
    localparam int unsigned COND_LT = 3;
    localparam int unsigned COND_GT = 2;
    localparam int unsigned COND_EQ = 1;
    localparam int unsigned COND_SO = 0;

    // Exception register bit positions
    localparam int unsigned XFLAG_SUM    = 1;
    localparam int unsigned XFLAG_EXCESS = 0;

    localparam logic [DATA_W-1:0]  RST_WORD  = 32'h0000_0000;
    localparam logic [COND_W-1:0]  RST_COND  = 4'h0;
    localparam logic [XFLAG_W-1:0] RST_XFLAG = 2'h0;

    typedef enum logic [1:0] {
        PAIR_CROSS,
        PAIR_HIGH,
        PAIR_LOW
    } hwmac_pair_t;

    typedef enum logic [2:0] {
        KIND_MUL,
        KIND_MAC_MOD,
        KIND_MAC_SAT,
        KIND_NMAC_MOD,
        KIND_NMAC_SAT
    } hwmac_kind_t;

    // Written to the op register; bit 7 is the MSB
    typedef struct packed {
        logic        oe;
        logic        record_bit;
        hwmac_kind_t kind;
        logic        uns;
        hwmac_pair_t pair;
    } hwmac_op_t;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        logic [DATA_W-1:0] raw;
        logic [DATA_W-1:0] addend;
        logic              ovf;
    } hwmac_res_t;

    localparam hwmac_op_t RST_OP = '0;

endpackage : hwmac_pkg

// ---- core/hwmac_unit.sv ----
// APB-mapped halfword multiply and multiply-accumulate unit with its own
// source, target, condition and exception registers.
// Assumes an APB master on pclk; a write to the op register executes at once.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module hwmac_unit (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [hwmac_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [hwmac_pkg::DATA_W-1:0]    pwdata,
    output logic      [hwmac_pkg::DATA_W-1:0]    prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    output logic      [hwmac_pkg::DATA_W-1:0]    target_gpr,
    output logic      [hwmac_pkg::COND_W-1:0]    condition_field_zero,
    output logic      [hwmac_pkg::XFLAG_W-1:0]   fixed_point_exception_reg
);
    import hwmac_pkg::*;

    logic [DATA_W-1:0]  src_a_q,  src_a_d;
    logic [DATA_W-1:0]  src_b_q,  src_b_d;
    logic [DATA_W-1:0]  target_q, target_d;
    hwmac_op_t          op_q,     op_d;
    logic [COND_W-1:0]  cr_q,     cr_d;
    logic [XFLAG_W-1:0] xflag_q,  xflag_d;
    logic [DATA_W-1:0]  rdata_q,  rdata_d;
    logic               err_q,    err_d;
    logic               wr_acc;
    logic               exec;
    logic               xflag_wr;
    hwmac_op_t          dp_op;
    hwmac_res_t         dp_res;

    hwmac_datapath u_datapath (
        .source_a_gpr (src_a_q),
        .source_b_gpr (src_b_q),
        .target_gpr   (target_q),
        .op           (dp_op),
        .res          (dp_res)
    );

    always_comb begin
        wr_acc   = psel && penable && pwrite;
        exec     = wr_acc && (paddr == OFS_OP);
        xflag_wr = wr_acc && (paddr == OFS_XFLAG);
        dp_op    = exec ? hwmac_op_t'(pwdata[OP_W-1:0]) : op_q;
        src_a_d  = src_a_q;
        src_b_d  = src_b_q;
        target_d = target_q;
        op_d     = op_q;
        cr_d     = cr_q;
        xflag_d  = xflag_q;
        rdata_d  = rdata_q;
        err_d    = err_q;
        if (wr_acc) begin
            if (paddr == OFS_SRC_A) begin
                src_a_d = pwdata;
            end else if (paddr == OFS_SRC_B) begin
                src_b_d = pwdata;
            end else if (paddr == OFS_TARGET) begin
                target_d = pwdata;
            end else if (paddr == OFS_COND) begin
                cr_d = pwdata[COND_W-1:0];
            end else if (paddr == OFS_XFLAG) begin
                xflag_d = pwdata[XFLAG_W-1:0];
            end
        end
        if (exec) begin
            op_d     = dp_op;
            target_d = dp_res.result;
            if (dp_op.oe && (dp_op.kind != KIND_MUL)) begin
                xflag_d[XFLAG_EXCESS] = dp_res.ovf;
                xflag_d[XFLAG_SUM]    = xflag_q[XFLAG_SUM] | dp_res.ovf;
            end
            if (dp_op.record_bit) begin
                cr_d[COND_LT] = dp_res.result[31];
                cr_d[COND_GT] = !dp_res.result[31] && (dp_res.result != RST_WORD);
                cr_d[COND_EQ] = (dp_res.result == RST_WORD);
                cr_d[COND_SO] = xflag_d[XFLAG_SUM];
            end
        end
        // Read data is captured in the setup cycle so prdata comes from a flop
        if (psel && !penable) begin
            err_d = 1'b0;
            if (paddr == OFS_SRC_A) begin
                rdata_d = src_a_q;
            end else if (paddr == OFS_SRC_B) begin
                rdata_d = src_b_q;
            end else if (paddr == OFS_TARGET) begin
                rdata_d = target_q;
            end else if (paddr == OFS_OP) begin
                rdata_d = {24'h00_0000, op_q};
            end else if (paddr == OFS_COND) begin
                rdata_d = {28'h000_0000, cr_q};
            end else if (paddr == OFS_XFLAG) begin
                rdata_d = {30'h0000_0000, xflag_q};
            end else begin
                rdata_d = RST_WORD;
                err_d   = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_a_q  <= RST_WORD;
            src_b_q  <= RST_WORD;
            target_q <= RST_WORD;
            op_q     <= RST_OP;
            cr_q     <= RST_COND;
            xflag_q  <= RST_XFLAG;
            rdata_q  <= RST_WORD;
            err_q    <= 1'b0;
        end else begin
            src_a_q  <= src_a_d;
            src_b_q  <= src_b_d;
            target_q <= target_d;
            op_q     <= op_d;
            cr_q     <= cr_d;
            xflag_q  <= xflag_d;
            rdata_q  <= rdata_d;
            err_q    <= err_d;
        end
    end

    // Zero wait states: every access phase completes in its first cycle
    assign pready                    = 1'b1;
    assign pslverr                   = err_q && psel && penable;
    assign prdata                    = rdata_q;
    assign target_gpr                = target_q;
    assign condition_field_zero      = cr_q;
    assign fixed_point_exception_reg = xflag_q;

    // Reference values: the products are computed independently of the datapath, the sums reuse dp_res.raw
    logic signed [31:0] chk_a_lo_s;
    logic signed [31:0] chk_b_hi_s;
    logic [31:0]        chk_cross_s;
    logic [31:0]        chk_low_u;
    logic [31:0]        chk_hh_u;
    logic [31:0]        chk_wrap;
    logic [31:0]        chk_neg;
    logic [32:0]        chk_usum;

    always_comb begin
        chk_a_lo_s  = {{16{src_a_q[15]}}, src_a_q[15:0]};
        chk_b_hi_s  = {{16{src_b_q[31]}}, src_b_q[31:16]};
        chk_cross_s = chk_a_lo_s * chk_b_hi_s;
        chk_low_u   = {16'h0000, src_a_q[15:0]} * {16'h0000, src_b_q[15:0]};
        chk_hh_u    = {16'h0000, src_a_q[31:16]} * {16'h0000, src_b_q[31:16]};
        chk_wrap    = dp_res.raw + target_q;
        chk_neg     = target_q - dp_res.raw;
        chk_usum    = {1'b0, dp_res.raw} + {1'b0, target_q};
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_cross_mul: assert property (
        exec && dp_op.kind == KIND_MUL && dp_op.pair == PAIR_CROSS && !dp_op.uns
        |=> target_q == $past(chk_cross_s))
        else $error("cross multiply result wrong");

    chk_low_mul: assert property (
        exec && dp_op.kind == KIND_MUL && dp_op.pair == PAIR_LOW && dp_op.uns
        |=> target_q == $past(chk_low_u))
        else $error("low halfword multiply result wrong");

    chk_mod_wrap: assert property (
        exec && dp_op.kind == KIND_MAC_MOD |=> target_q == $past(chk_wrap))
        else $error("modulo accumulate did not wrap");

    chk_sat_clamp: assert property (
        exec && dp_op.kind == KIND_MAC_SAT && !dp_op.uns
        && dp_res.raw[31] == target_q[31] && chk_wrap[31] != target_q[31]
        |=> target_q == {$past(target_q[31]), {31{~$past(target_q[31])}}})
        else $error("signed saturation value wrong");

    chk_usat_ones: assert property (
        exec && dp_op.kind == KIND_MAC_SAT && dp_op.uns && chk_usum[32]
        |=> target_q == 32'hFFFF_FFFF)
        else $error("unsigned saturation not all ones");

    chk_neg_acc: assert property (
        exec && dp_op.kind == KIND_NMAC_MOD |=> target_q == $past(chk_neg))
        else $error("negative accumulate result wrong");

    chk_mul_noflag: assert property (
        exec && dp_op.kind == KIND_MUL |=> $stable(xflag_q))
        else $error("multiply-only form changed exception flags");

    chk_hh_unsigned: assert property (
        exec && dp_op.kind == KIND_MUL && dp_op.pair == PAIR_HIGH && dp_op.uns
        |=> target_q == $past(chk_hh_u))
        else $error("unsigned high-high multiply wrong");

    chk_cond_record: assert property (
        exec && dp_op.record_bit
        |=> cr_q[COND_EQ] == (target_q == 32'h0000_0000)
            && cr_q[COND_SO] == xflag_q[XFLAG_SUM])
        else $error("condition field does not match result");

    chk_cond_hold: assert property (
        exec && !dp_op.record_bit |=> $stable(cr_q))
        else $error("condition field changed without record bit");

    chk_excess_update: assert property (
        exec && dp_op.oe && dp_op.kind != KIND_MUL
        |=> xflag_q[XFLAG_EXCESS] == $past(dp_res.ovf))
        else $error("overflow flag not updated");

    chk_so_sticky: assert property (
        xflag_q[XFLAG_SUM] && !xflag_wr |=> xflag_q[XFLAG_SUM])
        else $error("summary overflow cleared by hardware");

endmodule : hwmac_unit

// ---- testbench/hwmac_apb_host.sv ----
// APB host model standing in for the core side of the multiply-accumulate unit.
// Assumes one pclk domain; the host waits up to 64 cycles for pready before reporting late.
`timescale 1ns/1ps
module hwmac_apb_host (
    input  wire logic                         pclk,
    output logic                              psel,
    output logic                              penable,
    output logic                              pwrite,
    output logic [hwmac_pkg::ADDR_W-1:0]      paddr,
    output logic [hwmac_pkg::DATA_W-1:0]      pwdata,
    input  wire logic [hwmac_pkg::DATA_W-1:0] prdata,
    input  wire logic                         pready,
    input  wire logic                         pslverr
);
    import hwmac_pkg::*;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // Bounded wait: a hung slave is reported through late, never waited on forever
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic late);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        r    = prdata;
        e    = pslverr;
        late = (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        // Stale data must not look valid once released
        pwdata  <= ~d;
    endtask : xfer
endmodule : hwmac_apb_host

// ---- testbench/hwmac_unit_bench.sv ----
// Self-checking bench of the halfword multiply-accumulate unit.
// Assumes hwmac_apb_host performs every register access.
`timescale 1ns/1ps
module hwmac_unit_bench;
    import hwmac_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] target_gpr;
    logic [3:0]  cond;
    logic [1:0]  xflag;
    logic [3:0]  exp_cond;
    logic [1:0]  exp_xflag;
    int          errors;
    int          n_compared;
    logic [31:0] va[4] = '{32'h7FFF_8000, 32'hFFFF_0002, 32'hFFFF_FFFF, 32'h0000_0000};
    logic [31:0] vb[4] = '{32'h8000_7FFF, 32'h0003_FFFF, 32'hFFFF_FFFF, 32'h1234_5678};
    logic [31:0] vt[4] = '{32'h7FFF_0000, 32'h8000_0000, 32'hFFFF_FFF0, 32'h0000_0000};

    hwmac_unit u_hwmac_unit (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .psel                      (psel),
        .penable                   (penable),
        .pwrite                    (pwrite),
        .paddr                     (paddr),
        .pwdata                    (pwdata),
        .prdata                    (prdata),
        .pready                    (pready),
        .pslverr                   (pslverr),
        .target_gpr                (target_gpr),
        .condition_field_zero      (cond),
        .fixed_point_exception_reg (xflag)
    );

    hwmac_apb_host u_host (
        .pclk    (pclk),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
        logic late;
        u_host.xfer(w, a, d, r, e, late);
        if (late) begin
            errors++;
            end_sim();
        end
    endtask : io

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        io(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        io(1'b0, a, 32'h0000_0000, r, e);
        check(nm, r, exp);
        check({nm, "_err"}, {31'h0, e}, 32'h0000_0000);
    endtask : rd_chk

    // Returns overflow above the 32-bit value written to the target
    function automatic logic [32:0] ref_mac(input logic [31:0] a, b, t, input hwmac_op_t o);
        logic [31:0] x;
        logic [31:0] y;
        logic [31:0] p;
        logic [32:0] s;
        logic        sg;
        logic        exc;
        logic        neg;
        neg = o.kind inside {KIND_NMAC_MOD, KIND_NMAC_SAT};
        sg  = !o.uns || neg;
        x   = {16'h0000, (o.pair == PAIR_HIGH) ? a[31:16] : a[15:0]};
        y   = {16'h0000, (o.pair == PAIR_LOW) ? b[15:0] : b[31:16]};
        if (sg) begin
            x = {{16{x[15]}}, x[15:0]};
            y = {{16{y[15]}}, y[15:0]};
        end
        p  = neg ? -(x * y) : x * y;
        s  = {1'b0, p} + {1'b0, t};
        exc = sg ? (p[31] == t[31] && s[31] != t[31]) : s[32];
        case (o.kind)
            KIND_MUL: return {1'b0, p};
            KIND_MAC_SAT, KIND_NMAC_SAT: begin
                if (sg) return {exc, exc ? {t[31], {31{~t[31]}}} : s[31:0]};
                return {exc, s[31:0] | {32{s[32]}}};
            end
            default: return {exc, s[31:0]};
        endcase
    endfunction : ref_mac

    task automatic run_op(input hwmac_op_t o, input logic [31:0] a, b, t);
        logic [32:0] m;
        wr(OFS_SRC_A, a);
        wr(OFS_SRC_B, b);
        wr(OFS_TARGET, t);
        wr(OFS_OP, {24'h00_0000, o});
        m = ref_mac(a, b, t, o);
        if (o.oe && o.kind != KIND_MUL) exp_xflag = {exp_xflag[1] | m[32], m[32]};
        if (o.record_bit) exp_cond = {m[31], !m[31] && m[31:0] != 0, m[31:0] == 0, exp_xflag[1]};
        rd_chk("target", OFS_TARGET, m[31:0]);
        check("target_pin", target_gpr, m[31:0]);
        rd_chk("cond", OFS_COND, {28'h000_0000, exp_cond});
        check("cond_pin", {28'h000_0000, cond}, {28'h000_0000, exp_cond});
        rd_chk("xflag", OFS_XFLAG, {30'h0000_0000, exp_xflag});
        check("xflag_pin", {30'h0000_0000, xflag}, {30'h0000_0000, exp_xflag});
    endtask : run_op

    initial begin
        hwmac_op_t   o;
        logic [31:0] r;
        logic        e;
        errors     = 0;
        n_compared = 0;
        presetn    = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rd_chk("reset_reg", 8'(i * 4), RST_WORD);
        check("reset_pin", target_gpr, RST_WORD);
        io(1'b1, 8'h18, 32'hFFFF_FFFF, r, e);
        check("slverr_wr", {31'h0, e}, 32'h0000_0001);
        io(1'b0, 8'h18, 32'h0000_0000, r, e);
        check("slverr_rd", {31'h0, e}, 32'h0000_0001);
        check("unmapped_data", r, 32'h0000_0000);
        wr(OFS_COND, 32'hFFFF_FFFF);
        rd_chk("cond_width", OFS_COND, 32'h0000_000F);
        wr(OFS_XFLAG, 32'hFFFF_FFFF);
        rd_chk("xflag_width", OFS_XFLAG, 32'h0000_0003);
        wr(OFS_COND, 32'h0000_0000);
        exp_cond = 4'h0;
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            // Clearing the flags by software is allowed; hardware never clears summary
            wr(OFS_XFLAG, 32'h0000_0000);
            exp_xflag = 2'h0;
            for (int k = 0; k < 5; k++) begin
                for (int u = 0; u < 2; u++) begin
                    for (int p = 0; p < 3; p++) begin
                        o.kind       = hwmac_kind_t'(k);
                        o.pair       = hwmac_pair_t'(p);
                        o.uns        = 1'(u);
                        o.oe         = 1'((k + p + s) % 2);
                        o.record_bit = 1'((k + u + s) % 2);
                        run_op(o, va[s], vb[s], vt[s]);
                    end
                end
            end
            $display("test operand set %0d done", s);
        end
        end_sim();
    end
endmodule : hwmac_unit_bench
